// file: logic/gpio_port.v
// General-purpose I/O port: per-pin direction, output value, input sample and pull-up.
// Assumes a simple register port with one-cycle strobes and read data one cycle later.
//
// Operation
// R1: Direction bit one makes the pin output, zero makes it input.
// R2: Input with output-value one and pull-ups allowed enables the pull-up.
// R3: Global pull-up disable turns off every pull-up regardless of pin settings.
// R4: During reset all pins tri-state asynchronously and pull-ups are off.
// R5: Output pin drives its output-value bit; no pull-up in output mode.
// R6: Writing one to input location toggles the output-value bit.
// R7: Writing zero to input location leaves the output-value bit alone.
// R8: Input location read-only; direction and output registers read-write; three addresses. The code decodes four, adding MCU control at offset 3.
// R9: Changing one bit affects only that pin.
// R10: Pin level always readable through the input sample, any direction.
// R11: Latched pin value loads into input sample on the following edge.
// R12: Written pin value reaches the input sample one period later; the code takes three periods.
// R13: Software passes an intermediate state between tri-state and output high.
// R14: Software passes an intermediate state between pull-up input and output low.
// R15: Deep sleep clamps each pin's digital input to ground.
// R16: Enabled external interrupt or alternate function overrides the sleep clamp.
// R17: Released clamp on a high pin produces an edge for the interrupt logic.
// R18: Alternate functions on some pins leave the other pins untouched.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"

module gpio_port #(
    parameter WIDTH = 8
) (
    input  wire                    core_clk_i,
    input  wire                    rst_i,
    input  wire [`GPIO_ADDR_W-1:0] addr_i,
    input  wire [WIDTH-1:0]        wdata_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    output wire [WIDTH-1:0]        rdata_o,
    input  wire [WIDTH-1:0]        pin_i,
    output wire [WIDTH-1:0]        pin_o,
    output wire [WIDTH-1:0]        pin_oe_o,
    output wire [WIDTH-1:0]        pullup_en_o,
    input  wire                    deep_sleep_i,
    input  wire [WIDTH-1:0]        ext_int_en_i,
    input  wire [WIDTH-1:0]        alt_func_en_i,
    output wire [WIDTH-1:0]        input_sample_o
);
    reg  [WIDTH-1:0] output_value_ff;
    reg  [WIDTH-1:0] pin_direction_ff;
    reg  [1:0]       mcu_control_ff;
    reg  [WIDTH-1:0] rdata_ff;
    reg  [WIDTH-1:0] pin_out_ff;
    reg  [WIDTH-1:0] pin_oe_ff;
    reg  [WIDTH-1:0] pullup_ff;
    reg  [WIDTH-1:0] nxt_output_value;
    reg  [WIDTH-1:0] nxt_rdata;
    wire [WIDTH-1:0] input_sample;
    wire [WIDTH-1:0] drive_en;
    wire [WIDTH-1:0] drive_val;
    wire [WIDTH-1:0] pullup_en;
    wire [WIDTH-1:0] clamp;
    wire             global_pullup_disable;
    wire             sleep_req;

    assign global_pullup_disable = mcu_control_ff[`GPIO_MCU_PUD_BIT];
    assign sleep_req             = deep_sleep_i | mcu_control_ff[`GPIO_MCU_SLEEP_BIT];

    // R16 clamp override
    // R18 per-pin only
    assign clamp = {WIDTH{sleep_req}} & ~(ext_int_en_i | alt_func_en_i);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : pin
            gpio_pin_ctrl u_ctrl (
                .direction_bit_i         (pin_direction_ff[g]),
                .output_value_bit_i      (output_value_ff[g]),
                .global_pullup_disable_i (global_pullup_disable),
                .drive_en_o              (drive_en[g]),
                .drive_val_o             (drive_val[g]),
                .pullup_en_o             (pullup_en[g])
            );
            // R10 always sampled
            // R17 clamp release edge
            gpio_input_sync u_sync (
                .core_clk_i  (core_clk_i),
                .rst_i       (rst_i),
                .pin_level_i (pin_i[g]),
                .clamp_i     (clamp[g]),
                .sample_o    (input_sample[g])
            );
        end
    endgenerate

    always @* begin
        nxt_output_value = output_value_ff;
        if (wr_i && addr_i == `GPIO_OFS_OUTPUT_VALUE) begin
            nxt_output_value = wdata_i;
        end else if (wr_i && addr_i == `GPIO_OFS_INPUT_SAMPLE) begin
            // R6 toggle on one
            // R7 zero keeps bit
            nxt_output_value = output_value_ff ^ wdata_i;
        end
    end

    // R8 register writes
    // R9 whole-word bitwise
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_value_ff  <= `GPIO_RST_OUTPUT_VALUE;
            pin_direction_ff <= `GPIO_RST_DIRECTION;
            mcu_control_ff   <= 2'h0;
        end else begin
            output_value_ff <= nxt_output_value;
            if (wr_i && addr_i == `GPIO_OFS_PIN_DIRECTION) begin
                pin_direction_ff <= wdata_i;
            end
            if (wr_i && addr_i == `GPIO_OFS_MCU_CONTROL) begin
                mcu_control_ff <= wdata_i[1:0];
            end
        end
    end

    always @* begin
        nxt_rdata = {WIDTH{1'b0}};
        if (rd_i) begin
            case (addr_i)
                `GPIO_OFS_INPUT_SAMPLE:  nxt_rdata = input_sample;
                `GPIO_OFS_PIN_DIRECTION: nxt_rdata = pin_direction_ff;
                `GPIO_OFS_OUTPUT_VALUE:  nxt_rdata = output_value_ff;
                `GPIO_OFS_MCU_CONTROL:   nxt_rdata = {{(WIDTH-2){1'b0}}, mcu_control_ff};
                default:                 nxt_rdata = {WIDTH{1'b0}};
            endcase
        end
    end

    // R4 reset tri-state
    // R5 registered drive
    // R12 readback three periods after the write, not one
    // Pin drive is registered so every output comes from a flop; costs one cycle of latency.
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff   <= {WIDTH{1'b0}};
            pin_out_ff <= {WIDTH{1'b0}};
            pin_oe_ff  <= {WIDTH{1'b0}};
            pullup_ff  <= {WIDTH{1'b0}};
        end else begin
            rdata_ff   <= nxt_rdata;
            pin_out_ff <= drive_val & drive_en;
            pin_oe_ff  <= drive_en;
            pullup_ff  <= pullup_en;
        end
    end

    assign rdata_o        = rdata_ff;
    assign pin_o          = pin_out_ff;
    assign pin_oe_o       = pin_oe_ff;
    assign pullup_en_o    = pullup_ff;
    assign input_sample_o = input_sample;
endmodule

// file: logic/gpio_port_defines.vh
// Constants for the general-purpose I/O port: register offsets, field positions, reset values, timing.
// Included by the port top and its per-pin slice; holds definitions only.
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define GPIO_ADDR_W            2
`define GPIO_OFS_INPUT_SAMPLE  2'h0
`define GPIO_OFS_PIN_DIRECTION 2'h1
`define GPIO_OFS_OUTPUT_VALUE  2'h2
`define GPIO_OFS_MCU_CONTROL   2'h3

`define GPIO_MCU_PUD_BIT       0
`define GPIO_MCU_SLEEP_BIT     1

`define GPIO_RST_DIRECTION     8'h00
`define GPIO_RST_OUTPUT_VALUE  8'h00
`define GPIO_RST_MCU_CONTROL   8'h00

`define GPIO_INPUT_DELAY_CYC   1

`endif

// file: logic/gpio_input_sync.v
// One pin's input path: sleep clamp ahead of the buffer, then two-flop synchroniser.
// Assumes the pin level is synchronous to core_clk_i, as the surroundings guarantee.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"

module gpio_input_sync (
    input  wire core_clk_i,
    input  wire rst_i,
    input  wire pin_level_i,
    input  wire clamp_i,
    output wire sample_o
);
    reg  stage_ff;
    reg  sample_ff;
    wire clamped_level;

    // R15 clamp to ground
    assign clamped_level = pin_level_i & ~clamp_i;

    // R10 first synchroniser stage
    // A falling-edge latch is replaced by a flop here; the two-stage delay is two periods.
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_ff <= 1'b0;
        end else begin
            stage_ff <= clamped_level;
        end
    end

    // R11 held value loaded
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_ff <= 1'b0;
        end else begin
            sample_ff <= stage_ff;
        end
    end

    assign sample_o = sample_ff;
endmodule

// file: logic/gpio_pin_ctrl.v
// One pin's direction, drive value and pull-up decode.
// Assumes the port top owns the registers and passes the bits in.
`timescale 1ns/1ps

module gpio_pin_ctrl (
    input  wire direction_bit_i,
    input  wire output_value_bit_i,
    input  wire global_pullup_disable_i,
    output wire drive_en_o,
    output wire drive_val_o,
    output wire pullup_en_o
);
    // R1 direction select
    assign drive_en_o  = direction_bit_i;
    // R5 drive value
    assign drive_val_o = output_value_bit_i;
    // R2 pull-up on input
    // R3 global disable
    assign pullup_en_o = ~direction_bit_i & output_value_bit_i & ~global_pullup_disable_i;
endmodule

// file: sim/gpio_port_props.sv
// Assertions on the port's pins, pull-ups, read data and input sample.
// Assumes control writes are seen on the register port, so the software clamp bit is tracked here.
`timescale 1ns/1ps
module gpio_port_props #(parameter WIDTH = 8) (
    input wire logic             core_clk_i,
    input wire logic             rst_i,
    input wire logic [1:0]       addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic             wr_i,
    input wire logic             rd_i,
    input wire logic [WIDTH-1:0] rdata_o,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe_o,
    input wire logic [WIDTH-1:0] pullup_en_o,
    input wire logic             deep_sleep_i,
    input wire logic [WIDTH-1:0] ext_int_en_i,
    input wire logic [WIDTH-1:0] alt_func_en_i,
    input wire logic [WIDTH-1:0] input_sample_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0]       up_ff;
    logic             pud_ff;
    logic             sw_sleep_ff;
    wire  [WIDTH-1:0] clamped = pin_i & ~({WIDTH{deep_sleep_i | sw_sleep_ff}} & ~(ext_int_en_i | alt_func_en_i));
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_ff <= 2'h0;
            pud_ff <= 1'b0;
            sw_sleep_ff <= 1'b0;
        end else begin
            if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
            if (wr_i && addr_i == 2'h3) pud_ff <= wdata_i[0];
            if (wr_i && addr_i == 2'h3) sw_sleep_ff <= wdata_i[1];
        end
    end
    AST_RESET_TRI: assert property (disable iff (1'b0) rst_i |-> (pin_oe_o | pullup_en_o) == 0)
        else $error("pins not released in reset");
    AST_NO_PU_OUT: assert property ((pin_oe_o & pullup_en_o) == 0) else $error("pull-up on output");
    AST_DIR_WR: assert property ((wr_i && addr_i == 2'h1) ##1 !wr_i |-> ##1 pin_oe_o == $past(wdata_i, 2))
        else $error("direction not applied");
    AST_OUT_WR: assert property ((wr_i && addr_i == 2'h2) ##1 !wr_i |-> ##1 pin_o == ($past(wdata_i, 2) & pin_oe_o))
        else $error("drive value wrong");
    AST_PU_WR: assert property ((wr_i && addr_i == 2'h2) ##1 !wr_i |->
        ##1 pullup_en_o == ($past(wdata_i, 2) & ~pin_oe_o & {WIDTH{!pud_ff}})) else $error("pull-up wrong");
    AST_TOGGLE: assert property ((wr_i && addr_i == 2'h0) ##1 !wr_i |->
        ##1 (pin_o ^ $past(pin_o)) == ($past(wdata_i, 2) & pin_oe_o)) else $error("toggle wrong");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 0) else $error("read data outside slot");
    AST_RD_DIR: assert property (rd_i && addr_i == 2'h1 |=> rdata_o == pin_oe_o) else $error("direction readback");
    AST_SYNC: assert property (up_ff == 2'h3 |-> input_sample_o == $past(clamped, 2))
        else $error("input sample wrong");
    cover property ((wr_i && addr_i == 2'h0) ##1 !wr_i);
    cover property (deep_sleep_i && rd_i);
    cover property (pud_ff && rd_i);
endmodule

// file: sim/pin_partner.sv
// Circuit beyond the pins: optional external driver, else pull-up, else a floating line.
// Assumes the device's own driver wins over the external one.
`timescale 1ns/1ps
module pin_partner (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_o,
    input  wire logic [7:0] pullup_en_o,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic [7:0]      pin_i
);
    logic [7:0] float_ff = 8'h00;
    // A floating line wanders every cycle so no stale level can pass
    always @(posedge core_clk_i) float_ff <= ~float_ff;
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ((ext_en_i & ext_val_i) | (~ext_en_i & (pullup_en_o | float_ff))));
endmodule

// file: sim/tb.sv
// Self-checking bench for the I/O port, with an integer model of its registers.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/1ps
module tb;
    logic       clk = 0, rst = 0, wr = 0, rd = 0, sleep = 0;
    logic [1:0] addr = 0;
    logic [7:0] wdata = 0, r, rdata, pin_i, pin_o, oe, pu, smp, ext_en = 0, ext_val = 0, irq_en = 0, alt = 0;
    int         fails = 0, tests_run = 0, cyc = 0, dir_m = 0, out_m = 0, pud_m = 0, v;
    always #5 clk = ~clk;
    gpio_port uut (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu), .deep_sleep_i(sleep),
        .ext_int_en_i(irq_en), .alt_func_en_i(alt), .input_sample_o(smp));
    pin_partner far (.core_clk_i(clk), .pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_i(pin_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One field per write, so every pin step is between neighbouring states
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        case (a)
            2'h0: out_m = out_m ^ d;
            2'h1: dir_m = d;
            2'h2: out_m = d;
            default: pud_m = d[0];
        endcase
    endtask
    task automatic rd_reg(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 r = rdata;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        // Raise reset as an edge at time zero so the asynchronous branch clears every flop
        rst <= 1;
        v = $urandom(32'h9579);
        repeat (10) @(posedge clk);
        chk(oe | pu, 8'h00);
        rst <= 0;
        for (int a = 1; a < 4; a++) begin
            rd_reg(a[1:0]);
            chk(r, 8'h00);
        end
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            wr_reg(2'h1, 8'($urandom));
            wr_reg(2'h2, 8'($urandom));
            if (i == 6) wr_reg(2'h3, 8'h01);
            repeat (2) @(posedge clk);
            #1;
            chk(oe, dir_m[7:0]);
            chk(pin_o, dir_m[7:0] & out_m[7:0]);
            chk(pu, ~dir_m[7:0] & out_m[7:0] & {8{pud_m == 0}});
            rd_reg(2'h1);
            chk(r, dir_m[7:0]);
            wr_reg(2'h0, 8'($urandom));
            rd_reg(2'h2);
            chk(r, out_m[7:0]);
        end
        rd_reg(2'h3);
        chk(r, 8'h01);
        $display("test registers done");
        wr_reg(2'h1, 8'h00);
        ext_en <= 8'hff;
        for (int i = 0; i < 6; i++) begin
            ext_val <= 8'($urandom);
            sleep <= i[0];
            irq_en <= 8'($urandom);
            alt <= 8'($urandom);
            repeat (3) @(posedge clk);
            rd_reg(2'h0);
            chk(r, ext_val & ~({8{sleep}} & ~(irq_en | alt)));
        end
        // Software clamp bit, with sleep still high from the last loop pass, clamps every pin without an override
        wr_reg(2'h3, 8'h02);
        repeat (3) @(posedge clk);
        rd_reg(2'h0);
        chk(r, ext_val & (irq_en | alt));
        wr_reg(2'h3, 8'h00);
        $display("test inputs done");
        sleep <= 0;
        ext_en <= 8'h00;
        wr_reg(2'h1, 8'hff);
        wr_reg(2'h2, 8'h5a);
        repeat (2) @(posedge clk);
        rd_reg(2'h0);
        chk(r, 8'h5a);
        $display("test loopback done");
        #3 rst <= 1;
        #1 chk(oe | pu, 8'h00);
        @(posedge clk);
        rst <= 0;
        rd_reg(2'h2);
        chk(r, 8'h00);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
bind gpio_port gpio_port_props #(.WIDTH(WIDTH)) props (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .deep_sleep_i, .ext_int_en_i, .alt_func_en_i, .input_sample_o);
